// file: logic/ofc_pkg.sv
// constants, carrier types and crc step for the flow control receiver
package ofc_pkg;

   localparam int CAL_W      = 16;
   localparam int CRC_W      = 4;
   localparam int DEF_LANES  = 8;
   localparam int MAX_LANES  = 31;
   localparam int WB_ADR_W   = 8;
   localparam int WB_DAT_W   = 32;
   localparam int ERR_CNT_W  = 16;
   localparam int LINK_BIT   = 31;
   localparam int ERR_ST_LSB = 16;
   localparam int EV_W       = 4;

   localparam logic [CRC_W-1:0] CRC_POLY = 4'h3;
   localparam logic [CRC_W-1:0] CRC_INIT = 4'hf;

   localparam logic [WB_ADR_W-1:0] ADR_CTRL  = 8'h00;
   localparam logic [WB_ADR_W-1:0] ADR_EVENT = 8'h04;
   localparam logic [WB_ADR_W-1:0] ADR_MASK  = 8'h08;
   localparam logic [WB_ADR_W-1:0] ADR_CAL   = 8'h0c;
   localparam logic [WB_ADR_W-1:0] ADR_LSTS  = 8'h10;
   localparam logic [WB_ADR_W-1:0] ADR_ERRS  = 8'h14;

   localparam int   CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [EV_W-1:0] MASK_RST = 4'h0;

   typedef struct packed {
      logic clk;
      logic data;
      logic sync;
   } ofc_link_type;

   // lsb first: calendar good, calendar bad, status good, status bad
   typedef struct packed {
      logic st_bad;
      logic st_ok;
      logic cal_bad;
      logic cal_ok;
   } ofc_event_type;

   function automatic logic [CRC_W-1:0] ofc_crc_step(
      input logic [CRC_W-1:0] crc,
      input logic             din);
      logic fb;
      fb = crc[CRC_W-1] ^ din;
      ofc_crc_step = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
   endfunction

endpackage

// file: logic/ofc_sync.sv
// two-stage synchroniser for the incoming link pins
`timescale 1ns/100ps
module ofc_sync
   import ofc_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire ofc_link_type d_i,
   output ofc_link_type      q_o
);

   typedef struct packed {
      ofc_link_type meta;
      ofc_link_type stable;
   } ofc_sync_state_type;

   ofc_sync_state_type r;
   ofc_sync_state_type next_r;

   // first stage feeds only the second stage
   always_comb begin
      next_r        = r;
      next_r.meta   = d_i;
      next_r.stable = r.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.stable;

endmodule // ofc_sync

// file: logic/ofc_crc4.sv
// serial crc4 accumulator, one bit per enable
`timescale 1ns/100ps
module ofc_crc4
   import ofc_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clr_i,
   input  wire logic             en_i,
   input  wire logic             bit_i,
   output logic [CRC_W-1:0]      crc_o
);

   typedef struct packed {
      logic [CRC_W-1:0] crc;
   } ofc_crc_state_type;

   ofc_crc_state_type r;
   ofc_crc_state_type next_r;

   // a clear with an enable starts a block on its first bit
   always_comb begin
      next_r = r;
      if (clr_i && en_i) begin
         next_r.crc = ofc_crc_step(CRC_INIT, bit_i);
      end else if (clr_i) begin
         next_r.crc = CRC_INIT;
      end else if (en_i) begin
         next_r.crc = ofc_crc_step(r.crc, bit_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r.crc <= CRC_INIT;
      end else begin
         r <= next_r;
      end
   end

   assign crc_o = r.crc;

endmodule // ofc_crc4

// file: logic/ofc_rx.sv
// out-of-band flow control receiver with wishbone registers
`timescale 1ns/100ps
module ofc_rx
   import ofc_pkg::*;
#(
   parameter int LANES = DEF_LANES
)(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                fc_clk_i,
   input  wire logic                fc_data_i,
   input  wire logic                fc_sync_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [WB_DAT_W-1:0] wb_dat_i,
   output logic [WB_DAT_W-1:0]      wb_dat_o,
   output logic                     wb_ack_o,
   output logic [CAL_W-1:0]         calendar_o,
   output logic                     cal_update_o,
   output logic                     cal_error_o,
   output logic [LANES-1:0]         lane_status_o,
   output logic                     link_status_o,
   output logic                     stat_update_o,
   output logic                     stat_error_o,
   output logic                     irq_o
);

   localparam int ST_W    = LANES + 1;
   localparam int CAL_END = CAL_W + CRC_W;
   localparam int ST_DEND = CAL_END + ST_W;
   localparam int IDLE    = ST_DEND + CRC_W;
   localparam int CNT_W   = $clog2(IDLE + 1);

   localparam logic [CNT_W-1:0] P_ZERO    = '0;
   localparam logic [CNT_W-1:0] P_ONE     = CNT_W'(1);
   localparam logic [CNT_W-1:0] P_CAL_W   = CNT_W'(CAL_W);
   localparam logic [CNT_W-1:0] P_CAL_END = CNT_W'(CAL_END);
   localparam logic [CNT_W-1:0] P_ST_DEND = CNT_W'(ST_DEND);
   localparam logic [CNT_W-1:0] P_IDLE    = CNT_W'(IDLE);
   localparam logic [ERR_CNT_W-1:0] ERR_MAX = '1;

   generate
      if (LANES < 1 || LANES > MAX_LANES) begin : g_bad_lanes
         $error("ofc_rx: LANES out of range");
      end
   endgenerate

   typedef struct packed {
      logic                 clk_d;
      logic [CNT_W-1:0]     cnt;
      logic [CAL_W-1:0]     cal_sh;
      logic [ST_W-1:0]      st_sh;
      logic [CRC_W-1:0]     crc_sh;
      logic [CAL_W-1:0]     calendar;
      logic [LANES-1:0]     lane;
      logic                 link;
      ofc_event_type        pulse;
      logic                 ctrl_en;
      logic [EV_W-1:0]      events;
      logic [EV_W-1:0]      mask;
      logic [ERR_CNT_W-1:0] cal_errs;
      logic [ERR_CNT_W-1:0] st_errs;
      logic                 irq;
      logic                 ack;
      logic [WB_DAT_W-1:0]  dat;
   } ofc_rx_state_type;

   ofc_rx_state_type r;
   ofc_rx_state_type next_r;

   ofc_link_type     pins;
   ofc_link_type     lk;
   logic [CRC_W-1:0] crc_q;
   logic             crc_clr;
   logic             crc_en;
   logic             rise;
   logic             cal_end;
   logic             st_end;
   logic             crc_match;
   logic [CNT_W-1:0] pos;
   ofc_event_type    ev;
   logic             bus_req;
   logic             bus_wr;
   logic             bus_rd;
   logic [WB_DAT_W-1:0] rd_val;

   // member order of the link carrier: clk, data, sync
   assign pins = {fc_clk_i, fc_data_i, fc_sync_i};

   // pins are asynchronous to clk_i, so all three pass two flops
   ofc_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pins),
      .q_o   (lk)
   );

   ofc_crc4 u_crc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .clr_i (crc_clr),
      .en_i  (crc_en),
      .bit_i (lk.data),
      .crc_o (crc_q)
   );

   // edge found on the synchronised copy; needs clk_i at twice fc_clk
   assign rise = lk.clk & ~r.clk_d;

   assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
   // a write lands at the edge where the master samples ack high
   assign bus_wr  = wb_cyc_i & wb_stb_i & r.ack & wb_we_i;
   assign bus_rd  = bus_req & ~wb_we_i;

   always_comb begin
      rd_val = '0;
      unique case (wb_adr_i)
         ADR_CTRL:  rd_val[CTRL_EN_BIT] = r.ctrl_en;
         ADR_EVENT: rd_val[EV_W-1:0] = r.events;
         ADR_MASK:  rd_val[EV_W-1:0] = r.mask;
         ADR_CAL:   rd_val[CAL_W-1:0] = r.calendar;
         ADR_LSTS: begin
            rd_val[LANES-1:0] = r.lane;
            rd_val[LINK_BIT]  = r.link;
         end
         ADR_ERRS: begin
            rd_val[ERR_CNT_W-1:0] = r.cal_errs;
            rd_val[ERR_ST_LSB +: ERR_CNT_W] = r.st_errs;
         end
         default:   rd_val = '0;
      endcase
   end

   always_comb begin
      next_r    = r;
      crc_clr   = 1'b0;
      crc_en    = 1'b0;
      cal_end   = 1'b0;
      st_end    = 1'b0;
      ev        = '0;
      // a sync bit is position zero of a new frame
      pos       = lk.sync ? P_ZERO : r.cnt;
      crc_match = ({r.crc_sh[CRC_W-2:0], lk.data} == crc_q);

      next_r.clk_d = lk.clk;
      if (rise && r.ctrl_en) begin
         if (pos < P_IDLE) begin
            next_r.cnt = pos + P_ONE;
         end
         if (pos < P_CAL_W) begin
            crc_en        = 1'b1;
            crc_clr       = (pos == P_ZERO);
            next_r.cal_sh = {r.cal_sh[CAL_W-2:0], lk.data};
         end else if (pos < P_CAL_END) begin
            next_r.crc_sh = {r.crc_sh[CRC_W-2:0], lk.data};
            cal_end       = (pos == P_CAL_END - P_ONE);
         end else if (pos < P_ST_DEND) begin
            crc_en       = 1'b1;
            crc_clr      = (pos == P_CAL_END);
            next_r.st_sh = {r.st_sh[ST_W-2:0], lk.data};
         end else if (pos < P_IDLE) begin
            next_r.crc_sh = {r.crc_sh[CRC_W-2:0], lk.data};
            st_end        = (pos == P_IDLE - P_ONE);
         end
      end
      // disabled receiver waits for a fresh sync after re-enable
      if (!r.ctrl_en) begin
         next_r.cnt = P_IDLE;
      end

      ev.cal_ok  = cal_end & crc_match;
      ev.cal_bad = cal_end & ~crc_match;
      ev.st_ok   = st_end & crc_match;
      ev.st_bad  = st_end & ~crc_match;
      // indications are registered single pulses in clk_i
      next_r.pulse = ev;

      if (cal_end) begin
         next_r.calendar = r.cal_sh;
      end
      if (st_end) begin
         next_r.lane = r.st_sh[ST_W-1:1];
         next_r.link = r.st_sh[0];
      end
      if (ev.cal_bad && r.cal_errs != ERR_MAX) begin
         next_r.cal_errs = r.cal_errs + 1'b1;
      end
      if (ev.st_bad && r.st_errs != ERR_MAX) begin
         next_r.st_errs = r.st_errs + 1'b1;
      end

      // read of the event register clears it, a new event still lands
      if (bus_rd && wb_adr_i == ADR_EVENT) begin
         next_r.events = ev;
      end else begin
         next_r.events = r.events | ev;
      end

      if (bus_wr && wb_sel_i[0]) begin
         if (wb_adr_i == ADR_CTRL) begin
            next_r.ctrl_en = wb_dat_i[CTRL_EN_BIT];
         end
         if (wb_adr_i == ADR_MASK) begin
            next_r.mask = wb_dat_i[EV_W-1:0];
         end
      end
      // any write to the counter word zeroes both counters
      if (bus_wr && wb_adr_i == ADR_ERRS) begin
         next_r.cal_errs = '0;
         next_r.st_errs  = '0;
      end

      next_r.ack = bus_req;
      next_r.dat = bus_rd ? rd_val : '0;
      next_r.irq = |(next_r.events & next_r.mask);
   end

   // synchronous reset clears the state except cnt (loads P_IDLE) and ctrl_en (loads CTRL_EN_RST), regardless of the link clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r         <= '0;
         r.cnt     <= P_IDLE;
         r.ctrl_en <= CTRL_EN_RST;
         r.mask    <= MASK_RST;
      end else begin
         r <= next_r;
      end
   end

   assign wb_dat_o      = r.dat;
   assign wb_ack_o      = r.ack;
   assign calendar_o    = r.calendar;
   assign cal_update_o  = r.pulse.cal_ok;
   assign cal_error_o   = r.pulse.cal_bad;
   assign lane_status_o = r.lane;
   assign link_status_o = r.link;
   assign stat_update_o = r.pulse.st_ok;
   assign stat_error_o  = r.pulse.st_bad;
   assign irq_o         = r.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_sync_bit;
      rise && r.ctrl_en && lk.sync;
   endsequence

   property p_hold;
      (!rise && r.ctrl_en) |=> $stable(r.cnt);
   endproperty
   a_hold: assert property (p_hold)
      else $error("frame position moved without a link edge");

   property p_sync;
      s_sync_bit |=> (r.cnt == P_ONE);
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync bit did not restart the frame");

   property p_rst;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (!cal_update_o && !stat_update_o && !irq_o && !wb_ack_o);
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs active after reset");

   property p_cal_once;
      cal_update_o |=> !cal_update_o;
   endproperty
   a_cal_once: assert property (p_cal_once)
      else $error("calendar good longer than one cycle");

   property p_cal_ok;
      cal_update_o |-> ($past(cal_end) && $past(crc_match));
   endproperty
   a_cal_ok: assert property (p_cal_ok)
      else $error("calendar good without a clean block");

   property p_cal_bad;
      cal_error_o |-> ($past(cal_end) && !$past(crc_match) && !cal_update_o);
   endproperty
   a_cal_bad: assert property (p_cal_bad)
      else $error("calendar error without a failed block");

   property p_cal_val;
      (cal_update_o || cal_error_o) |-> (calendar_o == $past(r.cal_sh));
   endproperty
   a_cal_val: assert property (p_cal_val)
      else $error("calendar value not the received block");

   property p_st_ok;
      stat_update_o |-> ($past(st_end) && $past(crc_match) && !stat_error_o);
   endproperty
   a_st_ok: assert property (p_st_ok)
      else $error("status good without a clean block");

   property p_st_bad;
      stat_error_o |-> ($past(st_end) && !$past(crc_match));
   endproperty
   a_st_bad: assert property (p_st_bad)
      else $error("status error without a failed block");

   property p_st_val;
      (stat_update_o || stat_error_o) |->
         ({lane_status_o, link_status_o} == $past(r.st_sh));
   endproperty
   a_st_val: assert property (p_st_val)
      else $error("status value not the received block");

   property p_ack;
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus ack not a single cycle after request");

   property p_irq;
      ##1 (irq_o == |(r.events & r.mask));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not follow masked events");

endmodule // ofc_rx

// file: sim/ofc_tx_model.sv
// link partner model: sends calendar and status frames
`timescale 1ns/100ps
module ofc_tx_model
   import ofc_pkg::*;
#(
   parameter int LANES = DEF_LANES
)(
   output logic fc_clk_o,
   output logic fc_data_o,
   output logic fc_sync_o
);
   initial begin
      fc_clk_o  = 1'b0;
      fc_data_o = 1'b0;
      fc_sync_o = 1'b0;
   end

   // bits change while the clock is low, so they are stable at its rise;
   // the link runs far below its preferred top rate so that the system
   // clock stays above twice the link clock
   task automatic tx_bit(input logic d, input logic s);
      fc_data_o = d;
      fc_sync_o = s;
      #200 fc_clk_o = 1'b1;
      #200 fc_clk_o = 1'b0;
   endtask

   function automatic logic [3:0] crc(input logic [39:0] v, input int n);
      logic [3:0] c;
      c = 4'hf;
      for (int i = n - 1; i >= 0; i--) begin
         c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'h3 : 4'h0);
      end
      return c;
   endfunction

   // cx and sx flip crc bits on purpose to make a block corrupt
   task automatic send(input logic [CAL_W-1:0] cal, input logic se,
                       input logic [LANES:0] st, input logic [3:0] cx,
                       input logic [3:0] sx);
      logic [19:0]      cf;
      logic [LANES+4:0] sf;
      #13;
      cf = {cal, crc(40'(cal), CAL_W) ^ cx};
      for (int i = 19; i >= 0; i--) begin
         tx_bit(cf[i], i == 19);
      end
      if (se) begin
         sf = {st, crc(40'(st), LANES + 1) ^ sx};
         for (int i = LANES + 4; i >= 0; i--) begin
            tx_bit(sf[i], 1'b0);
         end
      end
      // clock stands still; released lines must not look held
      fc_data_o = ~fc_data_o;
      fc_sync_o = 1'b1;
   endtask
endmodule // ofc_tx_model

// file: sim/testbench.sv
// self-checking bench for the flow control receiver
`timescale 1ns/100ps
module testbench;
   import ofc_pkg::*;
   localparam int LANES = DEF_LANES;
   localparam int ST_W  = LANES + 1;
   logic                clk_i = 1'b0;
   logic                rst_i = 1'b1;
   logic                wb_cyc_i = 1'b0;
   logic                wb_stb_i = 1'b0;
   logic                wb_we_i = 1'b0;
   logic [WB_ADR_W-1:0] wb_adr_i = '0;
   logic [3:0]          wb_sel_i = '0;
   logic [WB_DAT_W-1:0] wb_dat_i = '0;
   logic [WB_DAT_W-1:0] wb_dat_o;
   logic                wb_ack_o;
   logic [CAL_W-1:0]    calendar_o;
   logic                cal_update_o;
   logic                cal_error_o;
   logic [LANES-1:0]    lane_status_o;
   logic                link_status_o;
   logic                stat_update_o;
   logic                stat_error_o;
   logic                irq_o;
   logic                fc_clk;
   logic                fc_data;
   logic                fc_sync;
   logic [CAL_W-1:0]    s_cal;
   logic [LANES:0]      s_st;
   logic [1:0]          s_ck;
   logic [1:0]          s_sk;
   logic [3:0]          ev_exp;
   logic [3:0]          mask;
   logic [15:0]         ec_c;
   logic [15:0]         ec_s;
   logic [31:0]         rd;
   int                  err_total = 0;
   int                  num_checks = 0;
   int                  n_cal = 0;
   int                  n_st = 0;

   always #25 clk_i = ~clk_i;

   ofc_rx #(.LANES(LANES)) u_dut (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .fc_clk_i      (fc_clk),
      .fc_data_i     (fc_data),
      .fc_sync_i     (fc_sync),
      .wb_cyc_i      (wb_cyc_i),
      .wb_stb_i      (wb_stb_i),
      .wb_we_i       (wb_we_i),
      .wb_adr_i      (wb_adr_i),
      .wb_sel_i      (wb_sel_i),
      .wb_dat_i      (wb_dat_i),
      .wb_dat_o      (wb_dat_o),
      .wb_ack_o      (wb_ack_o),
      .calendar_o    (calendar_o),
      .cal_update_o  (cal_update_o),
      .cal_error_o   (cal_error_o),
      .lane_status_o (lane_status_o),
      .link_status_o (link_status_o),
      .stat_update_o (stat_update_o),
      .stat_error_o  (stat_error_o),
      .irq_o         (irq_o)
   );

   ofc_tx_model #(.LANES(LANES)) u_tx (
      .fc_clk_o  (fc_clk),
      .fc_data_o (fc_data),
      .fc_sync_o (fc_sync)
   );

   // pulses counted per cycle high, so a stretched pulse shows up
   always @(negedge clk_i) begin
      if (!rst_i && (cal_update_o | cal_error_o) === 1'b1) begin
         n_cal++;
         s_cal = calendar_o;
         s_ck = {cal_error_o, cal_update_o};
      end
      if (!rst_i && (stat_update_o | stat_error_o) === 1'b1) begin
         n_st++;
         s_st = {lane_status_o, link_status_o};
         s_sk = {stat_error_o, stat_update_o};
      end
   end

   task automatic results();
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wb(input logic we, input logic [WB_ADR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         results();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input string nm, input logic [WB_ADR_W-1:0] a,
                       input logic [31:0] e);
      wb(1'b0, a, 32'h0, rd);
      chk(nm, e, rd);
   endtask

   function automatic logic [3:0] ev_of(input logic en, input logic se,
                                        input logic [3:0] cx,
                                        input logic [3:0] sx);
      if (!en) return 4'h0;
      return {se && sx != 0, se && sx == 0, cx != 0, cx == 0};
   endfunction

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("cal_rst", 0, calendar_o);
      chk("lane_rst", 0, {lane_status_o, link_status_o});
      chk("irq_rst", 0, irq_o);
      ev_exp = '0;
      ec_c = '0;
      ec_s = '0;
      rchk("ctrl_rst", ADR_CTRL, 32'(CTRL_EN_RST));
      rchk("mask_rst", ADR_MASK, 32'(MASK_RST));
      rchk("unmapped", 8'h20, 32'h0);
      rchk("err_rst", ADR_ERRS, 32'h0);
   endtask

   // en low: receiver disabled, no pulse may come
   task automatic frame(input logic en, input logic se,
                        input logic [3:0] cx, input logic [3:0] sx);
      logic [CAL_W-1:0] cal;
      logic [LANES:0]   st;
      int               ec;
      int               es;
      int               n;
      cal = CAL_W'($urandom);
      st = ST_W'($urandom);
      mask = 4'($urandom);
      ec = n_cal + int'(en);
      es = n_st + int'(en & se);
      wb(1'b1, ADR_MASK, 32'(mask), rd);
      u_tx.send(cal, se, st, cx, sx);
      n = 0;
      while ((n_cal != ec || n_st != es) && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 40) begin
         err_total++;
         results();
      end
      repeat (10) @(posedge clk_i);
      chk("cal_pulses", ec, n_cal);
      chk("st_pulses", es, n_st);
      if (en) begin
         chk("calendar", cal, s_cal);
         chk("cal_kind", {cx != 0, cx == 0}, s_ck);
         rchk("cal_reg", ADR_CAL, 32'(cal));
      end
      if (en & se) begin
         chk("status", st, s_st);
         chk("st_kind", {sx != 0, sx == 0}, s_sk);
         rchk("lane_reg", ADR_LSTS,
              (32'(st[0]) << LINK_BIT) | 32'(st[LANES:1]));
      end
      ev_exp = ev_exp | ev_of(en, se, cx, sx);
      ec_c = ec_c + 16'(en && cx != 0);
      ec_s = ec_s + 16'(en && se && sx != 0);
      chk("irq", 32'(|(ev_exp & mask)), irq_o);
      rchk("events", ADR_EVENT, 32'(ev_exp));
      ev_exp = '0;
      chk("irq_clr", 0, irq_o);
   endtask

   initial begin
      void'($urandom(32'he990));
      do_reset();
      frame(1'b1, 1'b1, 4'h0, 4'h0);
      frame(1'b1, 1'b1, 4'h8, 4'h0);
      frame(1'b1, 1'b1, 4'h0, 4'h1);
      frame(1'b1, 1'b0, 4'h1, 4'h0);
      wb(1'b1, ADR_CTRL, 32'h0, rd);
      frame(1'b0, 1'b1, 4'h0, 4'h0);
      wb(1'b1, ADR_CTRL, 32'h1, rd);
      for (int i = 0; i < 16; i++) begin
         frame(1'b1, 1'($urandom), 4'($urandom) & {4{1'($urandom)}},
               4'($urandom) & {4{1'($urandom)}});
      end
      rchk("err_cnt", ADR_ERRS, {ec_s, ec_c});
      wb(1'b1, ADR_ERRS, 32'h0, rd);
      rchk("err_clr", ADR_ERRS, 32'h0);
      do_reset();
      frame(1'b1, 1'b1, 4'h0, 4'h0);
      results();
   end
endmodule // testbench
